// File: design/controller_error_recorder.sv
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
//
// Contract
// - scan longer than watch time sets cycle overrun flag, code 809F.
// - parallel mode periph pass over 2 s sets periph flag, code 809F.
// - system stop instr sets stop flag, code C100+number, numbers 1..511.
// - alarm instr writes code 4100+number for numbers 1..511.
// - alarm instr also sets user alarm flag.
// - one executed flag per alarm number 1..511, set on execution.
// - simultaneous errors: only most serious code is recorded.
// - non-fatal error in run: run lamp on, fault lamp flashes.
// - enabled cyclic/interrupt unit access conflict: flag, 008B, task no.
// - enabled unit access in interrupt during io refresh: same error.
// - cyclic refresh left on plus interrupt access: duplicate, error.
// - detection enable at setup bit 14; disabled suppresses the error.
// - report maximum interrupt task processing time observed.
module controller_error_recorder #(
  parameter longint PERIPH_LIMIT = err_rec_pkg::PERIPH_CYCLES,
  parameter longint FLASH_HALF   = err_rec_pkg::FLASH_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  output logic             irq,
  input  wire logic        run_mode,
  input  wire logic        parallel_mode,
  input  wire logic        scan_tick,
  input  wire logic        periph_start,
  input  wire logic        periph_end,
  input  wire logic        system_stop_error_instr,
  input  wire logic        user_alarm_error_instr,
  input  wire logic [8:0]  user_number,
  input  wire logic        unit_conflict,
  input  wire logic        intr_access_in_refresh,
  input  wire logic        intr_access_cyclic_on,
  input  wire logic [7:0]  intr_task_number,
  input  wire logic        intr_task_busy,
  output logic             run_indicator,
  output logic             fault_alarm_indicator,
  output logic             fatal_stop
);

  // ****************************************************************
  // registers
  // ****************************************************************
  localparam int NUM_F = err_rec_pkg::NUM_EVENTS;
  logic [15:0] error_code_word_reg;
  logic [NUM_F-1:0] flags_reg;
  logic [15:0] conflict_task_number_word_reg;
  logic [15:0] max_interrupt_time_word_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] watch_reg;
  logic [4:0]  irq_stat_reg;
  logic [4:0]  irq_mask_reg;
  logic [511:0] alarm_seen_reg;
  logic [15:0] scan_cnt_reg;
  logic [15:0] int_cnt_reg;
  logic [31:0] periph_cnt_reg;
  logic        periph_busy_reg;
  logic [31:0] flash_cnt_reg;
  logic        flash_reg;

  // ****************************************************************
  // event detection
  // ****************************************************************
  wire detect_en = ctrl_reg[err_rec_pkg::CTRL_DETECT];
  wire num_ok    = user_number != 9'h000;
  wire ev_cycle  = scan_cnt_reg > watch_reg;
  wire ev_periph = parallel_mode && periph_busy_reg &&
                   periph_cnt_reg >= PERIPH_LIMIT[31:0];
  wire ev_stop   = system_stop_error_instr && num_ok;
  wire ev_alarm  = user_alarm_error_instr && num_ok;
  wire ev_confl  = detect_en && (unit_conflict ||
                   intr_access_in_refresh ||
                   intr_access_cyclic_on);
  wire [NUM_F-1:0] events = {ev_confl, ev_alarm, ev_stop,
                             ev_periph, ev_cycle};
  wire [11:0] user_code = 12'(user_number) + err_rec_pkg::USER_OFFSET;
  wire clear_op = reg_write && reg_addr == err_rec_pkg::ADDR_CTRL &&
                  reg_wdata[err_rec_pkg::CTRL_CLEAR];
  wire [511:0] alarm_set = {511'h0, ev_alarm} << user_number;

  // ****************************************************************
  // priority: fatal first, then alarm, then conflict
  // ****************************************************************
  logic [15:0] new_code;
  always_comb begin
    if (ev_cycle || ev_periph)
      new_code = err_rec_pkg::CODE_OVERRUN;
    else if (ev_stop)
      new_code = err_rec_pkg::CODE_STOP | 16'(user_code);
    else if (ev_alarm)
      new_code = err_rec_pkg::CODE_ALARM | 16'(user_code);
    else if (ev_confl)
      new_code = err_rec_pkg::CODE_CONFLICT;
    else
      new_code = err_rec_pkg::CODE_NONE;
  end
  wire any_fatal_now = ev_cycle || ev_periph || ev_stop;
  wire held_fatal    = error_code_word_reg[15];
  wire any_event     = |events;
  // a held fatal code is not overwritten by a non-fatal one
  wire code_load = any_event && (!held_fatal || any_fatal_now);
  wire nonfatal_held = (flags_reg[err_rec_pkg::FLAG_ALARM] ||
                        flags_reg[err_rec_pkg::FLAG_CONFL]) &&
                       !fatal_stop;

  // ****************************************************************
  // register read mux
  // ****************************************************************
  wire in_alarm = reg_addr >= err_rec_pkg::ADDR_ALARM_LO;
  wire [4:0] alarm_word = 5'(reg_addr - err_rec_pkg::ADDR_ALARM_LO);
  wire [15:0] alarm_rd = alarm_seen_reg[{alarm_word, 4'h0} +: 16];
  logic [15:0] rd_mux;
  always_comb begin
    case (reg_addr)
      err_rec_pkg::ADDR_CODE:     rd_mux = error_code_word_reg;
      err_rec_pkg::ADDR_FLAGS:    rd_mux = 16'(flags_reg);
      err_rec_pkg::ADDR_TASK:     rd_mux = conflict_task_number_word_reg;
      err_rec_pkg::ADDR_MAXINT:   rd_mux = max_interrupt_time_word_reg;
      err_rec_pkg::ADDR_CTRL:     rd_mux = ctrl_reg;
      err_rec_pkg::ADDR_IRQ_STAT: rd_mux = 16'(irq_stat_reg);
      err_rec_pkg::ADDR_IRQ_MASK: rd_mux = 16'(irq_mask_reg);
      err_rec_pkg::ADDR_WATCH:    rd_mux = watch_reg;
      default:                    rd_mux = in_alarm ? alarm_rd : 16'h0000;
    endcase
  end
  wire stat_rd = reg_read && reg_addr == err_rec_pkg::ADDR_IRQ_STAT;

  // ****************************************************************
  // bus and control
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata    <= 16'h0000;
      ctrl_reg     <= err_rec_pkg::CTRL_RESET;
      watch_reg    <= err_rec_pkg::WATCH_RESET;
      irq_mask_reg <= 5'h00;
    end else begin
      reg_rdata <= reg_read ? rd_mux : 16'h0000;
      if (reg_write && reg_addr == err_rec_pkg::ADDR_CTRL)
        ctrl_reg <= reg_wdata & err_rec_pkg::CTRL_RESET;
      if (reg_write && reg_addr == err_rec_pkg::ADDR_WATCH)
        watch_reg <= reg_wdata;
      if (reg_write && reg_addr == err_rec_pkg::ADDR_IRQ_MASK)
        irq_mask_reg <= reg_wdata[4:0];
    end
  end

  // ****************************************************************
  // sticky error state
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      error_code_word_reg           <= err_rec_pkg::CODE_NONE;
      flags_reg                     <= '0;
      conflict_task_number_word_reg <= 16'h0000;
      alarm_seen_reg                <= '0;
      fatal_stop                    <= 1'b0;
    end else begin
      if (code_load)
        error_code_word_reg <= new_code;
      else if (clear_op)
        error_code_word_reg <= err_rec_pkg::CODE_NONE;
      flags_reg <= (clear_op ? '0 : flags_reg) | events;
      if (ev_confl)
        conflict_task_number_word_reg <= 16'(intr_task_number);
      alarm_seen_reg <= (clear_op ? '0 : alarm_seen_reg) |
                        alarm_set;
      if (any_fatal_now)
        fatal_stop <= 1'b1;
      else if (clear_op)
        fatal_stop <= 1'b0;
    end
  end

  // ****************************************************************
  // timers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_cnt_reg    <= 16'h0000;
      periph_cnt_reg  <= 32'h0000_0000;
      periph_busy_reg <= 1'b0;
    end else begin
      if (scan_tick)
        scan_cnt_reg <= 16'h0000;
      else if (scan_cnt_reg != 16'hFFFF && run_mode)
        scan_cnt_reg <= scan_cnt_reg + 16'h0001;
      if (periph_end || !parallel_mode)
        periph_busy_reg <= 1'b0;
      else if (periph_start)
        periph_busy_reg <= 1'b1;
      if (periph_start || !periph_busy_reg)
        periph_cnt_reg <= 32'h0000_0000;
      else if (periph_cnt_reg != 32'hFFFF_FFFF)
        periph_cnt_reg <= periph_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_cnt_reg                 <= 16'h0000;
      max_interrupt_time_word_reg <= 16'h0000;
    end else begin
      if (!intr_task_busy)
        int_cnt_reg <= 16'h0000;
      else if (int_cnt_reg != 16'hFFFF)
        int_cnt_reg <= int_cnt_reg + 16'h0001;
      if (clear_op)
        max_interrupt_time_word_reg <= 16'h0000;
      else if (int_cnt_reg > max_interrupt_time_word_reg)
        max_interrupt_time_word_reg <= int_cnt_reg;
    end
  end

  // ****************************************************************
  // indicators and interrupt
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_cnt_reg         <= 32'h0000_0000;
      flash_reg             <= 1'b0;
      run_indicator         <= 1'b0;
      fault_alarm_indicator <= 1'b0;
      irq_stat_reg          <= 5'h00;
      irq                   <= 1'b0;
    end else begin
      if (flash_cnt_reg >= FLASH_HALF[31:0] - 32'h0000_0001) begin
        flash_cnt_reg <= 32'h0000_0000;
        flash_reg     <= !flash_reg;
      end else begin
        flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
      end
      run_indicator <= run_mode && !fatal_stop;
      fault_alarm_indicator <= fatal_stop ||
                               (nonfatal_held && flash_reg);
      irq_stat_reg <= (stat_rd ? 5'h00 : irq_stat_reg) | events;
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_alarm_code: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    ev_alarm && !ev_cycle && !ev_periph && !ev_stop && !held_fatal
    |=> error_code_word_reg[15:12] == 4'h4 &&
        error_code_word_reg[11:0] == 12'($past(user_number)) + 12'h100 &&
        flags_reg[err_rec_pkg::FLAG_ALARM])
    else $error("alarm code not recorded");
  chk_stop_code: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    ev_stop && !ev_cycle && !ev_periph
    |=> error_code_word_reg[15:12] == 4'hC &&
        error_code_word_reg[11:0] == 12'($past(user_number)) + 12'h100)
    else $error("stop code wrong");
  chk_overrun_code: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    ev_cycle |=> error_code_word_reg == 16'h809F &&
                 flags_reg[err_rec_pkg::FLAG_CYCLE])
    else $error("overrun code wrong");
  chk_conflict_gate: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !detect_en && !flags_reg[err_rec_pkg::FLAG_CONFL]
    |=> !flags_reg[err_rec_pkg::FLAG_CONFL])
    else $error("conflict flagged while disabled");
  chk_alarm_bit: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    ev_alarm |=> alarm_seen_reg[$past(user_number)])
    else $error("executed alarm bit not set");
  chk_flag_hold: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    flags_reg[0] && !clear_op |=> flags_reg[0])
    else $error("flag dropped without clear");
  chk_task_store: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    ev_confl |=> conflict_task_number_word_reg[7:0] ==
                 $past(intr_task_number) && flags_reg[4])
    else $error("task number not stored");
  chk_max_grows: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !clear_op |=> max_interrupt_time_word_reg >=
                 $past(max_interrupt_time_word_reg))
    else $error("max interrupt time shrank");
  chk_run_lamp: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    run_mode && !fatal_stop |=> run_indicator)
    else $error("run lamp off on non-fatal");
  chk_periph_code: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    ev_periph |=> error_code_word_reg == 16'h809F &&
                  flags_reg[err_rec_pkg::FLAG_PERIPH])
    else $error("peripheral overrun not recorded");
  chk_lesser_held: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    held_fatal && !any_fatal_now && !clear_op
    |=> error_code_word_reg == $past(error_code_word_reg))
    else $error("held fatal code overwritten");
  chk_conflict_code: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    ev_confl && !ev_alarm && !any_fatal_now && !held_fatal
    |=> error_code_word_reg == 16'h008B)
    else $error("conflict code not recorded");
  chk_fault_steady: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    fatal_stop |=> fault_alarm_indicator)
    else $error("fault lamp not steady on fatal");
  chk_alarm_clear: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    clear_op && !ev_alarm |=> alarm_seen_reg == '0)
    else $error("executed alarm bits not cleared");

endmodule

// File: design/err_rec_pkg.sv
package err_rec_pkg;

  // ****************************************************************
  // register indices on the plain port
  // ****************************************************************
  localparam logic [5:0] ADDR_CODE      = 6'h00;
  localparam logic [5:0] ADDR_FLAGS     = 6'h01;
  localparam logic [5:0] ADDR_TASK      = 6'h02;
  localparam logic [5:0] ADDR_MAXINT    = 6'h03;
  localparam logic [5:0] ADDR_CTRL      = 6'h04;
  localparam logic [5:0] ADDR_IRQ_STAT  = 6'h05;
  localparam logic [5:0] ADDR_IRQ_MASK  = 6'h06;
  localparam logic [5:0] ADDR_WATCH     = 6'h07;
  localparam logic [5:0] ADDR_ALARM_LO  = 6'h20;
  localparam logic [5:0] ADDR_ALARM_HI  = 6'h3F;

  // ****************************************************************
  // flag positions in the flags word
  // ****************************************************************
  localparam int FLAG_CYCLE   = 0;
  localparam int FLAG_PERIPH  = 1;
  localparam int FLAG_STOP    = 2;
  localparam int FLAG_ALARM   = 3;
  localparam int FLAG_CONFL   = 4;
  localparam int NUM_EVENTS   = 5;

  // ctrl word: bit 0 clears errors, bit 14 conflict detection enable
  localparam int CTRL_CLEAR   = 0;
  localparam int CTRL_DETECT  = 14;
  localparam logic [15:0] CTRL_RESET  = 16'h4000;
  localparam logic [15:0] WATCH_RESET = 16'h0064;

  // ****************************************************************
  // error codes
  // ****************************************************************
  localparam logic [15:0] CODE_NONE     = 16'h0000;
  localparam logic [15:0] CODE_OVERRUN  = 16'h809F;
  localparam logic [15:0] CODE_STOP     = 16'hC000;
  localparam logic [15:0] CODE_ALARM    = 16'h4000;
  localparam logic [15:0] CODE_CONFLICT = 16'h008B;
  localparam logic [11:0] USER_OFFSET   = 12'h100;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ          = 50_000_000;
  localparam int PERIPH_LIMIT_MS = 2000;
  localparam longint PERIPH_CYCLES =
    longint'(CLK_HZ) / 1000 * PERIPH_LIMIT_MS;
  localparam int FLASH_HALF_MS   = 250;
  localparam longint FLASH_CYCLES =
    longint'(CLK_HZ) / 1000 * FLASH_HALF_MS;

  typedef enum logic [1:0] {
    SEV_NONE  = 2'b00,
    SEV_NONF  = 2'b01,
    SEV_FATAL = 2'b10
  } sev_t;

endpackage

// File: bench/scan_engine_model.sv
`timescale 1ns/1ns
// ****************************************
// scan engine: scan ends, peripheral passes
// ****************************************
module scan_engine_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] scan_len,
  input  wire logic [7:0] periph_len,
  output logic            scan_tick,
  output logic            periph_start,
  output logic            periph_end
);
  logic [7:0] scan_cnt = 8'h00;
  logic [7:0] per_cnt  = 8'h00;
  wire        scan_end = (scan_len != 8'h00) &&
                         (scan_cnt >= scan_len - 8'h01);
  wire        per_on   = (periph_len != 8'h00);
  // zero length idles that activity
  always @(posedge core_clk) begin
    scan_tick    <= scan_end;
    scan_cnt     <= scan_end ? 8'h00 : scan_cnt + 8'h01;
    periph_start <= per_on && (per_cnt == 8'h00);
    periph_end   <= per_on && (per_cnt == periph_len);
    per_cnt      <= (per_cnt >= periph_len) ? 8'h00 : per_cnt + 8'h01;
  end
endmodule

// File: bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [5:0]  reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic        irq;
  logic        run_mode = 1'b1;
  logic        parallel_mode = 1'b0;
  logic        scan_tick;
  logic        periph_start;
  logic        periph_end;
  logic [4:0]  ev = 5'h00;
  logic [8:0]  user_number = 9'h000;
  logic [7:0]  intr_task_number = 8'h00;
  logic        intr_task_busy = 1'b0;
  logic        run_indicator;
  logic        fault_alarm_indicator;
  logic        fatal_stop;
  logic [7:0]  scan_len = 8'h08;
  logic [7:0]  periph_len = 8'h00;
  logic [15:0] d;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          n;
  int          c;

  always #10 core_clk = ~core_clk;

  controller_error_recorder #(.PERIPH_LIMIT(50), .FLASH_HALF(4)) dut (
    .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .irq, .run_mode, .parallel_mode, .scan_tick, .periph_start,
    .periph_end, .system_stop_error_instr(ev[0]),
    .user_alarm_error_instr(ev[1]), .user_number, .unit_conflict(ev[2]),
    .intr_access_in_refresh(ev[3]), .intr_access_cyclic_on(ev[4]),
    .intr_task_number, .intr_task_busy, .run_indicator,
    .fault_alarm_indicator, .fatal_stop
  );
  scan_engine_model far_side (
    .core_clk, .scan_len, .periph_len, .scan_tick, .periph_start, .periph_end
  );

  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic fire(input logic [4:0] m, input logic [8:0] u);
    @(posedge core_clk);
    ev               <= m;
    user_number      <= u;
    intr_task_number <= u[7:0];
    @(posedge core_clk);
    ev <= 5'h00;
  endtask
  task automatic clr();
    wr(err_rec_pkg::ADDR_CTRL, 16'h4001);
  endtask
  // flash shows as several changes in 20 cycles
  task automatic toggles(output int t);
    logic p;
    t = 0;
    p = fault_alarm_indicator;
    repeat (20) begin
      @(posedge core_clk);
      #1;
      if (fault_alarm_indicator !== p) t++;
      p = fault_alarm_indicator;
    end
  endtask
  function automatic logic [15:0] ucode(input logic [15:0] p, input int u);
    return p + 16'h0100 + 16'(u);
  endfunction
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #400_000;
    n_mismatch++;
    wrap_up();
  end

  // ****************
  // sequence
  // ****************
  initial begin
    void'($urandom(32'hc241_b3e2));
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(err_rec_pkg::ADDR_CTRL, d);
    chk(d, 16'h4000);
    wr(6'h10, 16'hFFFF);
    rd(6'h10, d);
    chk(d, 16'h0000);
    done("reset");
    for (int i = 0; i < 6; i++) begin
      n = (i == 0) ? 1 : (i == 1) ? 511 : $urandom_range(1, 511);
      fire(5'h02, 9'(n));
      rd(err_rec_pkg::ADDR_CODE, d);
      chk(d, ucode(16'h4000, n));
      rd(err_rec_pkg::ADDR_FLAGS, d);
      chk(d, 16'h0008);
      rd(err_rec_pkg::ADDR_ALARM_LO + 6'(n / 16), d);
      chk(16'(d[n % 16]), 16'h0001);
      toggles(c);
      chk(16'(c > 1 && run_indicator === 1'b1), 16'h0001);
      rd(err_rec_pkg::ADDR_CODE, d);
      chk(d, ucode(16'h4000, n));
      clr();
    end
    done("alarm");
    n = $urandom_range(1, 511);
    fire(5'h01, 9'(n));
    fire(5'h02, 9'h001);
    rd(err_rec_pkg::ADDR_CODE, d);
    chk(d, ucode(16'hC000, n));
    rd(err_rec_pkg::ADDR_FLAGS, d);
    chk(d, 16'h000C);
    chk(16'(fatal_stop), 16'h0001);
    chk(16'({run_indicator, fault_alarm_indicator}), 16'h0001);
    clr();
    rd(err_rec_pkg::ADDR_CODE, d);
    chk(d, 16'h0000);
    fire(5'h03, 9'(n));
    rd(err_rec_pkg::ADDR_CODE, d);
    chk(d, ucode(16'hC000, n));
    clr();
    fire(5'h06, 9'(n));
    rd(err_rec_pkg::ADDR_CODE, d);
    chk(d, ucode(16'h4000, n));
    clr();
    done("stop and priority");
    for (int k = 2; k < 5; k++) begin
      n = $urandom_range(0, 255);
      fire(5'(5'h01 << k), 9'(n));
      rd(err_rec_pkg::ADDR_CODE, d);
      chk(d, 16'h008B);
      rd(err_rec_pkg::ADDR_FLAGS, d);
      chk(d, 16'h0010);
      rd(err_rec_pkg::ADDR_TASK, d);
      chk(d, 16'(n));
      clr();
    end
    wr(err_rec_pkg::ADDR_CTRL, 16'h0000);
    fire(5'h1C, 9'h005);
    rd(err_rec_pkg::ADDR_FLAGS, d);
    chk(d, 16'h0000);
    wr(err_rec_pkg::ADDR_CTRL, 16'h4000);
    done("conflict");
    rd(err_rec_pkg::ADDR_IRQ_STAT, d);
    wr(err_rec_pkg::ADDR_IRQ_MASK, 16'h0008);
    fire(5'h02, 9'h005);
    repeat (2) @(posedge core_clk);
    #1;
    chk(16'(irq), 16'h0001);
    rd(err_rec_pkg::ADDR_IRQ_STAT, d);
    chk(d, 16'h0008);
    repeat (2) @(posedge core_clk);
    #1;
    chk(16'(irq), 16'h0000);
    wr(err_rec_pkg::ADDR_IRQ_MASK, 16'h0000);
    fire(5'h02, 9'h006);
    repeat (2) @(posedge core_clk);
    #1;
    chk(16'(irq), 16'h0000);
    clr();
    done("irq");
    n = $urandom_range(5, 30);
    @(posedge core_clk);
    intr_task_busy <= 1'b1;
    repeat (n) @(posedge core_clk);
    intr_task_busy <= 1'b0;
    repeat (2) @(posedge core_clk);
    intr_task_busy <= 1'b1;
    repeat (2) @(posedge core_clk);
    intr_task_busy <= 1'b0;
    rd(err_rec_pkg::ADDR_MAXINT, d);
    chk(d, 16'(n));
    done("max time");
    wr(err_rec_pkg::ADDR_WATCH, 16'h000A);
    repeat (30) @(posedge core_clk);
    rd(err_rec_pkg::ADDR_FLAGS, d);
    chk(d, 16'h0000);
    scan_len <= 8'h1E;
    repeat (40) @(posedge core_clk);
    scan_len <= 8'h08;
    rd(err_rec_pkg::ADDR_FLAGS, d);
    chk(d, 16'h0001);
    rd(err_rec_pkg::ADDR_CODE, d);
    chk(d, 16'h809F);
    wr(err_rec_pkg::ADDR_WATCH, 16'h0064);
    clr();
    done("cycle overrun");
    @(posedge core_clk);
    parallel_mode <= 1'b1;
    periph_len    <= 8'h14;
    repeat (80) @(posedge core_clk);
    rd(err_rec_pkg::ADDR_FLAGS, d);
    chk(d, 16'h0000);
    periph_len <= 8'h50;
    repeat (120) @(posedge core_clk);
    rd(err_rec_pkg::ADDR_FLAGS, d);
    chk(d, 16'h0002);
    rd(err_rec_pkg::ADDR_CODE, d);
    chk(d, 16'h809F);
    done("peripheral overrun");
    wrap_up();
  end
endmodule
